// *** test/dsc_host_model.sv ***
`timescale 1ns/1ps
module dsc_host_model
  import dsc_pkg::*;
#(
  parameter int SETTLE_CYCLES = 40
)
(
  // Clock
  input wire logic sys_clk,
  // Serial pins toward the device
  output dsc_serial_t serialIn
);
  // Idle pins high from time zero
  initial serialIn = SERIAL_IDLE;

  // Levels held six cycles, four more than the port needs
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One framed byte, bit 0 first; opcode shared with device
  task automatic send_byte(input logic [7:0] b);
    serialIn.csN = 1'b0;
    hold(6);
    for (int i = 0; i < BYTE_BITS; i++) begin
      serialIn.shiftClockN = 1'b0;
      serialIn.data = b[i];
      hold(6);
      serialIn.shiftClockN = 1'b1;
      hold(6);
    end
    serialIn.csN = 1'b1;
    serialIn.data = ~serialIn.data; // Released line inverts the last data bit
    hold(6);
  endtask

  // Wake pulse, csN back high, clock still while settling
  task automatic wake();
    serialIn.csN = 1'b0;
    hold(6);
    serialIn.csN = 1'b1;
    hold(SETTLE_CYCLES);
  endtask
endmodule // dsc_host_model

// *** test/dsc_standby_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin \
  $display("wrong value %s exp %h got %h", nm, exp, got); failures++; end end
module dsc_standby_ctrl_tb_top
  import dsc_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  dsc_serial_t serialIn;
  logic [DOT_WIDTH-1:0] dotPattern = '0;
  logic [GRID_WIDTH-1:0] gridPattern = '0;
  logic [DOT_WIDTH-1:0] dotDrive;
  logic [GRID_WIDTH-1:0] gridDrive;
  logic oscEnable, logicRun, standbyActive;
  int failures = 0;
  int cmpCount = 0;

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  dsc_standby_ctrl dut (.sys_clk(sys_clk), .rst(rst), .serialIn(serialIn),
    .dotPattern(dotPattern), .gridPattern(gridPattern), .dotDrive(dotDrive),
    .gridDrive(gridDrive), .oscEnable(oscEnable), .logicRun(logicRun),
    .standbyActive(standbyActive));
  dsc_host_model host (.sys_clk(sys_clk), .serialIn(serialIn));

  // Dot lines expected for an all-lights selection, high wins
  function automatic logic [DOT_WIDTH-1:0] want_dot(input logic [1:0] hl);
    if (hl[1]) return '1;
    if (hl[0]) return '0;
    return dotPattern;
  endfunction

  task automatic new_pats();
    dotPattern = DOT_WIDTH'({$urandom(), $urandom()});
    gridPattern = GRID_WIDTH'($urandom());
  endtask

  // Lets the sync stages and the two output edges pass
  task automatic settle();
    repeat (12) @(negedge sys_clk);
  endtask

  task automatic check_state(input string nm,
      input logic [DOT_WIDTH-1:0] d, input logic sb);
    `CHK({nm, " dot"}, d, dotDrive)
    `CHK({nm, " grid"}, sb ? {GRID_WIDTH{1'b0}} : gridPattern, gridDrive)
    `CHK({nm, " osc"}, ~sb, oscEnable)
    `CHK({nm, " run"}, ~sb, logicRun)
    `CHK({nm, " sby"}, sb, standbyActive)
    $display("test %s done", nm);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, well past the expected run
  initial begin
    #25000;
    failures++;
    end_sim();
  end

  // Main sequence, random spare bits and patterns
  initial begin
    void'($urandom(2));
    repeat (2) @(negedge sys_clk);
    new_pats();
    rst = 1'b0;
    settle();
    check_state("reset", '0, 1'b0);
    for (int m = 0; m < 8; m++) begin
      new_pats();
      host.send_byte({ALL_LIGHTS_OP, 2'($urandom()), 2'(m)});
      settle();
      check_state("lights", want_dot(2'(m)), 1'b0);
    end
    host.send_byte(STANDBY_OPCODE);
    settle();
    check_state("standby", '0, 1'b1);
    new_pats();
    host.wake();
    check_state("wake", '0, 1'b0);
    host.send_byte({ALL_LIGHTS_OP, 4'h0});
    settle();
    check_state("normal", dotPattern, 1'b0);
    host.send_byte({4'h3, 4'($urandom())});
    settle();
    check_state("ignored", dotPattern, 1'b0);
    host.send_byte(STANDBY_OPCODE);
    settle();
    check_state("standby normal", '0, 1'b1);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    settle();
    check_state("standby reset", '0, 1'b0);
    end_sim();
  end
endmodule // dsc_standby_ctrl_tb_top

// *** verilog/dsc_pkg.sv ***
package dsc_pkg;

  // Serial command bytes arrive LSB first, eight shift clocks per byte
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;

  // Output widths of one dot line and of the grid drivers
  localparam int DOT_WIDTH = 35;
  localparam int GRID_WIDTH = 24;

  // Command encodings, upper nibble selects all-lights, standby is a whole byte
  localparam logic [3:0] ALL_LIGHTS_OP = 4'h7;
  localparam logic [7:0] STANDBY_OPCODE = 8'hF0;

  // Levels of the serial pins while idle
  localparam logic [2:0] SERIAL_IDLE = 3'h7;

  // Pins of the serial command port
  typedef struct packed {
    logic csN;
    logic shiftClockN;
    logic data;
  } dsc_serial_t;

  // Layout of a command byte, bit 0 is the first bit shifted in
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] spare;
    logic high;
    logic low;
  } dsc_cmd_t;

  // State of the segment outputs
  typedef enum {
    MODE_NORMAL,
    MODE_ALL_LOW,
    MODE_ALL_HIGH
  } dsc_mode_t;

endpackage

// *** verilog/dsc_standby_ctrl.sv ***
`timescale 1ns/1ps
module dsc_standby_ctrl
  import dsc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Serial command port pins
  input wire dsc_serial_t serialIn,
  // Patterns from the display scan logic
  input wire logic [DOT_WIDTH-1:0] dotPattern,
  input wire logic [GRID_WIDTH-1:0] gridPattern,
  // Driver outputs and power state
  output logic [DOT_WIDTH-1:0] dotDrive,
  output logic [GRID_WIDTH-1:0] gridDrive,
  output logic oscEnable,
  output logic logicRun,
  output logic standbyActive
);

  // Map the two select bits onto a display state; high wins
  function automatic dsc_mode_t decodeMode(input logic low, input logic high);
    if (high) begin
      return MODE_ALL_HIGH;
    end
    return low ? MODE_ALL_LOW : MODE_NORMAL;
  endfunction

  // Whole-byte match, so a stray byte can never put the part to sleep
  function automatic logic isStandby(input logic [7:0] b);
    return b == STANDBY_OPCODE;
  endfunction

  // Synchroniser stages and filtered pin levels
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic [2:0] syncC_q;
  logic [2:0] filt_q;
  logic [2:0] filtPrev_q;
  logic csLow;
  logic clkRise;
  logic csFall;
  // Byte assembly and command decode
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  logic [7:0] nextByte;
  logic byteDone;
  logic standbyCmd;
  dsc_cmd_t cmd;
  // Power and display state
  logic standby_q;
  dsc_mode_t mode_q;

  // Three-stage synchroniser; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      syncA_q <= SERIAL_IDLE;
      syncB_q <= SERIAL_IDLE;
      syncC_q <= SERIAL_IDLE;
      filt_q <= SERIAL_IDLE;
      filtPrev_q <= SERIAL_IDLE;
    end else begin
      syncA_q <= serialIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      for (int i = 0; i < 3; i++) begin
        if (syncB_q[i] == syncC_q[i]) begin
          filt_q[i] <= syncC_q[i];
        end
      end
      filtPrev_q <= filt_q;
    end
  end

  // Edges of the filtered pins; bit 2 chip select, 1 shift clock, 0 data
  assign csLow = !filt_q[2];
  assign csFall = filtPrev_q[2] && !filt_q[2];
  assign clkRise = !filtPrev_q[1] && filt_q[1];
  assign nextByte = {filt_q[0], shift_q[7:1]};
  assign cmd = dsc_cmd_t'(nextByte);
  assign byteDone = !standby_q && csLow && clkRise && bitCnt_q == BIT_CNT_LAST;
  assign standbyCmd = byteDone && isStandby(nextByte);

  // Shift register; frozen in standby since the real clock would be stopped
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shift_q <= 8'h00;
      bitCnt_q <= BIT_CNT_RESET;
    end else if (standby_q || !csLow) begin
      bitCnt_q <= BIT_CNT_RESET;
    end else if (clkRise) begin
      shift_q <= nextByte;
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end

  // Standby entry on its opcode, exit on a falling chip select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      standby_q <= 1'b0;
    end else if (standbyCmd) begin
      standby_q <= 1'b1;
    end else if (standby_q && csFall) begin
      standby_q <= 1'b0;
    end
  end

  // Display state; power-up and standby both leave it all off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_ALL_LOW;
    end else if (standbyCmd) begin
      mode_q <= MODE_ALL_LOW;
    end else if (byteDone && cmd.op == ALL_LIGHTS_OP) begin
      mode_q <= decodeMode(cmd.low, cmd.high);
    end
  end

  // Registered drivers; grids follow the scan only while running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dotDrive <= '0;
      gridDrive <= '0;
      oscEnable <= 1'b1;
      logicRun <= 1'b1;
      standbyActive <= 1'b0;
    end else begin
      gridDrive <= standby_q ? '0 : gridPattern;
      oscEnable <= !standby_q;
      logicRun <= !standby_q;
      standbyActive <= standby_q;
      case (mode_q)
        MODE_NORMAL: dotDrive <= standby_q ? '0 : dotPattern;
        MODE_ALL_LOW: dotDrive <= '0;
        MODE_ALL_HIGH: dotDrive <= '1;
        default: dotDrive <= '0;
      endcase
    end
  end

  standby_entry_a: assert property (@(posedge sys_clk)
    disable iff (rst) standbyCmd |=> ##1
    dotDrive == '0 && gridDrive == '0)
    else $error("display not off after standby command");

  grid_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_q |=> gridDrive == '0 && !oscEnable && !logicRun)
    else $error("grids or oscillator active in standby");

  halt_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_q |-> !byteDone && bitCnt_q == BIT_CNT_RESET)
    else $error("command logic running in standby");

  reset_init_a: assert property (@(posedge sys_clk)
    $past(rst) |-> !standby_q && mode_q == MODE_ALL_LOW)
    else $error("state not initial after reset");

  wake_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_q && csFall |=> !standby_q ##1 oscEnable)
    else $error("no wake on chip select fall");

  keep_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(standby_q) |-> (mode_q == MODE_ALL_LOW) [*2])
    else $error("display not all off after wake");

  all_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    byteDone && cmd.op == ALL_LIGHTS_OP && cmd.low && !cmd.high
    |=> ##1 dotDrive == '0)
    else $error("dots not forced low");

  all_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    byteDone && cmd.op == ALL_LIGHTS_OP && cmd.high |=> ##1 dotDrive == '1)
    else $error("dots not forced high");

  opcode_a: assert property (@(posedge sys_clk) disable iff (rst)
    byteDone && nextByte == STANDBY_OPCODE |=> standby_q && standbyActive == 0
    ##1 standbyActive)
    else $error("standby opcode not taken");

  // Normal display passes the scan pattern one edge after the mode lands
  normal_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    byteDone && cmd.op == ALL_LIGHTS_OP && !cmd.low && !cmd.high
    |=> ##1 dotDrive == $past(dotPattern))
    else $error("dots not following pattern in normal display");

  // Dot, oscillator, run and standby outputs hold their start values through reset
  reset_outputs_a: assert property (@(posedge sys_clk)
    $past(rst) |-> dotDrive == '0 && oscEnable && logicRun && !standbyActive)
    else $error("outputs not initial after reset");

  // Standby entry forces all-low, nothing may rewrite it while asleep
  keep_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_q |=> $stable(mode_q))
    else $error("display setting changed in standby");

  // Halted logic: the shift register must not move
  shift_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_q |=> $stable(shift_q))
    else $error("shift register moved in standby");

  dots_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    standbyActive |-> dotDrive == '0 && gridDrive == '0)
    else $error("display lit in standby");

  // Wake restarts the logic and the grid scan two edges after the fall
  wake_run_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_q && csFall |=> ##1 logicRun && !standbyActive &&
    gridDrive == $past(gridPattern))
    else $error("logic not running after wake");

  wake_dark_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(standbyActive) |-> dotDrive == '0)
    else $error("display lit right after wake");

endmodule // dsc_standby_ctrl
